// ===== common/srx_pkg.sv
// Notes on behaviour
// - byte-count request block: length 5, wait, status loc, 2 unused, 4402, timeout, count, dest
// - string read uses command 4403; count word carries the terminator instead
// - the timeout word counts whole seconds
// - status word located by its memory type and an offset that is address minus one
// - characters land at the destination memory type and address of the request
// - first returned word holds the count of characters transferred
// - second returned word holds characters still buffered after the transfer
// - characters packed two per word from the third word, earlier one in low byte
// - odd count into word memory clears the high byte of the last word
// - every arriving character goes into the receive buffer while it has room, request or not
// - characters arriving while the buffer is full are dropped and overflow is flagged
// - string read takes characters up to the terminator and delivers them
// - a zero-count read returns only the buffered count, no data
// - string read waits for its terminator or timeout; port status records the cause
// - a zero timeout never expires; request waits for data or cancel
// - a failed read delivers nothing and leaves buffered data in place
// - byte-count read waits for enough characters or the timeout
// - the completion status word is written only when the request finishes
package srx_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PSTAT = 8'h04;
    localparam logic [7:0] OFF_RXCNT = 8'h08;
    localparam logic [7:0] OFF_BLK = 8'h40;
    // request block word indices
    localparam int BLK_WORDS = 11;
    localparam int BLK_LEN = 0;
    localparam int BLK_WAIT = 1;
    localparam int BLK_STTYPE = 2;
    localparam int BLK_STOFF = 3;
    localparam int BLK_CMD = 6;
    localparam int BLK_TMO = 7;
    localparam int BLK_CNT = 8;
    localparam int BLK_DTYPE = 9;
    localparam int BLK_DADDR = 10;
    // request block values
    localparam logic [15:0] BLK_LEN_READ = 16'h0005;
    localparam logic [15:0] CMD_READ_BYTES = 16'h1132;
    localparam logic [15:0] CMD_READ_STRING = 16'h1133;
    localparam logic [15:0] TERM_MAX = 16'h00ff;
    localparam logic [15:0] MEM_TYPE_WORD = 16'h8000;
    // control and port status fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_CANCEL = 1;
    localparam int CTRL_BUSY = 0;
    localparam int PSTAT_OVF = 0;
    localparam int PSTAT_CAUSE_LSB = 1;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_DATA = 2'h1;
    localparam logic [1:0] CAUSE_TIMEOUT = 2'h2;
    localparam logic [1:0] CAUSE_FAIL = 2'h3;
    // completion status word codes
    localparam logic [15:0] ST_OK = 16'h0001;
    localparam logic [15:0] ST_TIMEOUT = 16'h0002;
    localparam logic [15:0] ST_CANCELLED = 16'h0003;
    localparam logic [15:0] ST_BADREQ = 16'h0004;
    // buffer and timing
    localparam int RXBUF_DEPTH = 64;
    localparam int NS_PER_SECOND = 1000000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICKS_PER_SEC = NS_PER_SECOND / CLK_PERIOD_NS;
endpackage : srx_pkg

// ===== hw/srx_rxbuf.sv
`timescale 1ns/1ps
`default_nettype none
module srx_rxbuf #(
    parameter int DEPTH = srx_pkg::RXBUF_DEPTH,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic pop,
    input wire logic [CW-1:0] peek_idx,
    output logic [7:0] peek_data,
    output logic [7:0] head_data,
    output logic [CW-1:0] count,
    output logic dropped
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_W = (AW + 1)'(DEPTH);

    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic do_push;
    logic [AW:0] peek_sum;

    // full buffer refuses the character
    assign do_push = push && (cnt_reg != CW'(DEPTH));
    assign dropped = push && (cnt_reg == CW'(DEPTH));
    assign count = cnt_reg;
    assign head_data = mem[rd_reg];

    // peek an entry relative to the head, wrapping round
    always_comb
    begin
        peek_sum = (AW + 1)'(rd_reg) + (AW + 1)'(peek_idx);
        if (peek_sum >= DEPTH_W)
        begin
            peek_sum = peek_sum - DEPTH_W;
        end
        peek_data = mem[peek_sum[AW-1:0]];
    end

    // pointer and count update
    always_comb
    begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (do_push)
        begin
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop)
        begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        if (do_push && !pop)
        begin
            cnt_next = cnt_reg + 1'b1;
        end
        else if (!do_push && pop)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (do_push)
        begin
            mem[wr_reg] <= push_data;
        end
    end
endmodule : srx_rxbuf
`default_nettype wire

// ===== hw/srx_serial_rx.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module srx_serial_rx #(
    parameter int DEPTH = srx_pkg::RXBUF_DEPTH,
    parameter int TICKS_PER_SECOND = srx_pkg::TICKS_PER_SEC
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic MEM_WE,
    output logic [15:0] MEM_TYPE,
    output logic [15:0] MEM_ADDR,
    output logic [15:0] MEM_DATA,
    output logic [1:0] MEM_BE
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef enum logic [2:0] {
        S_IDLE, S_CHECK, S_WAIT, S_XFER, S_CNT, S_REM, S_STAT
    } srx_state_t;

    srx_state_t state_reg, state_next;
    logic [15:0] blk_reg [srx_pkg::BLK_WORDS];
    logic [15:0] blk_next [srx_pkg::BLK_WORDS];
    logic ovf_reg, ovf_next;
    logic [1:0] cause_reg, cause_next;
    logic [31:0] prdata_reg, prdata_next;
    logic err_reg, err_next;
    logic [15:0] len_reg, len_next, done_reg, done_next;
    logic [7:0] lo_reg, lo_next;
    logic odd_reg, odd_next;
    logic [CW-1:0] scan_reg, scan_next;
    logic [31:0] tick_reg, tick_next;
    logic [15:0] sec_reg, sec_next;
    logic [15:0] code_reg, code_next;
    logic we_reg, we_next;
    logic [15:0] mtype_reg, mtype_next, maddr_reg, maddr_next, mdata_reg, mdata_next;
    logic [1:0] be_reg, be_next;

    logic buf_pop, buf_drop;
    logic [7:0] peek_data, head_data;
    logic [CW-1:0] buf_count;
    logic setup, wr_acc, busy, in_blk, mapped, go, cancel;
    logic [7:0] blk_off;
    logic [3:0] blk_idx;
    logic word_dest;

    srx_rxbuf #(
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_rxbuf (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .push(RX_VALID),
        .push_data(RX_DATA),
        .pop(buf_pop),
        .peek_idx(scan_reg),
        .peek_data(peek_data),
        .head_data(head_data),
        .count(buf_count),
        .dropped(buf_drop)
    );

    // apb decode
    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign busy = (state_reg != S_IDLE);
    assign blk_off = PADDR - srx_pkg::OFF_BLK;
    assign blk_idx = blk_off[5:2];
    assign in_blk = (PADDR >= srx_pkg::OFF_BLK) && (PADDR[1:0] == 2'h0)
        && (blk_off[7:2] < 6'(srx_pkg::BLK_WORDS));
    assign mapped = in_blk || (PADDR == srx_pkg::OFF_CTRL) || (PADDR == srx_pkg::OFF_PSTAT)
        || (PADDR == srx_pkg::OFF_RXCNT);
    assign go = wr_acc && (PADDR == srx_pkg::OFF_CTRL) && PWDATA[srx_pkg::CTRL_GO]
        && !busy;
    assign cancel = wr_acc && (PADDR == srx_pkg::OFF_CTRL) && PWDATA[srx_pkg::CTRL_CANCEL];
    assign word_dest = (blk_reg[srx_pkg::BLK_DTYPE] == srx_pkg::MEM_TYPE_WORD);

    // register file, read data and overflow flag
    always_comb
    begin
        blk_next = blk_reg;
        prdata_next = prdata_reg;
        err_next = err_reg;
        // overflow set wins over software clear
        ovf_next = buf_drop || (ovf_reg && !(wr_acc && (PADDR == srx_pkg::OFF_PSTAT)
            && PWDATA[srx_pkg::PSTAT_OVF]));
        if (setup)
        begin
            err_next = !mapped || (PWRITE && in_blk && busy);
            prdata_next = '0;
            if (!PWRITE)
            begin
                if (in_blk)
                begin
                    prdata_next = {16'h0000, blk_reg[blk_idx]};
                end
                else if (PADDR == srx_pkg::OFF_CTRL)
                begin
                    prdata_next[srx_pkg::CTRL_BUSY] = busy;
                end
                else if (PADDR == srx_pkg::OFF_PSTAT)
                begin
                    prdata_next[srx_pkg::PSTAT_OVF] = ovf_reg;
                    prdata_next[srx_pkg::PSTAT_CAUSE_LSB +: 2] = cause_reg;
                end
                else if (PADDR == srx_pkg::OFF_RXCNT)
                begin
                    prdata_next = 32'(buf_count);
                end
            end
        end
        // block words are frozen while a request runs
        if (wr_acc && in_blk && !busy)
        begin
            blk_next[blk_idx] = PWDATA[15:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            for (int i = 0; i < srx_pkg::BLK_WORDS; i++)
            begin
                blk_reg[i] <= 16'h0000;
            end
            prdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end
        else
        begin
            blk_reg <= blk_next;
            prdata_reg <= prdata_next;
            err_reg <= err_next;
            ovf_reg <= ovf_next;
        end
    end

    // request sequencer
    always_comb
    begin
        state_next = state_reg;
        cause_next = cause_reg;
        len_next = len_reg;
        done_next = done_reg;
        lo_next = lo_reg;
        odd_next = odd_reg;
        scan_next = scan_reg;
        tick_next = tick_reg;
        sec_next = sec_reg;
        code_next = code_reg;
        we_next = 1'b0;
        mtype_next = mtype_reg;
        maddr_next = maddr_reg;
        mdata_next = mdata_reg;
        be_next = be_reg;
        buf_pop = 1'b0;
        unique case (state_reg)
            S_IDLE:
            begin
                if (go)
                begin
                    tick_next = '0;
                    sec_next = '0;
                    done_next = '0;
                    odd_next = 1'b0;
                    scan_next = '0;
                    state_next = S_CHECK;
                end
            end
            S_CHECK:
            begin
                if (blk_reg[srx_pkg::BLK_LEN] != srx_pkg::BLK_LEN_READ
                    || (blk_reg[srx_pkg::BLK_CMD] != srx_pkg::CMD_READ_BYTES
                    && blk_reg[srx_pkg::BLK_CMD] != srx_pkg::CMD_READ_STRING)
                    || (blk_reg[srx_pkg::BLK_CMD] == srx_pkg::CMD_READ_STRING
                    && blk_reg[srx_pkg::BLK_CNT] > srx_pkg::TERM_MAX))
                begin
                    code_next = srx_pkg::ST_BADREQ;
                    cause_next = srx_pkg::CAUSE_FAIL;
                    state_next = S_STAT;
                end
                else if (blk_reg[srx_pkg::BLK_CMD] == srx_pkg::CMD_READ_BYTES
                    && blk_reg[srx_pkg::BLK_CNT] == 16'h0000)
                begin
                    len_next = '0;
                    state_next = S_CNT;
                end
                else
                begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT:
            begin
                // one-second enable from the divider
                if (tick_reg == 32'(TICKS_PER_SECOND - 1))
                begin
                    tick_next = '0;
                    sec_next = sec_reg + 1'b1;
                end
                else
                begin
                    tick_next = tick_reg + 1'b1;
                end
                if (cancel)
                begin
                    code_next = srx_pkg::ST_CANCELLED;
                    cause_next = srx_pkg::CAUSE_FAIL;
                    state_next = S_STAT;
                end
                else if (blk_reg[srx_pkg::BLK_TMO] != 16'h0000
                    && sec_reg >= blk_reg[srx_pkg::BLK_TMO])
                begin
                    code_next = srx_pkg::ST_TIMEOUT;
                    cause_next = srx_pkg::CAUSE_TIMEOUT;
                    state_next = S_STAT;
                end
                else if (blk_reg[srx_pkg::BLK_CMD] == srx_pkg::CMD_READ_BYTES)
                begin
                    if (32'(buf_count) >= 32'(blk_reg[srx_pkg::BLK_CNT]))
                    begin
                        len_next = blk_reg[srx_pkg::BLK_CNT];
                        state_next = S_XFER;
                    end
                end
                else if (scan_reg < buf_count)
                begin
                    // scan one buffered character per cycle for the terminator
                    if (peek_data == blk_reg[srx_pkg::BLK_CNT][7:0])
                    begin
                        len_next = 16'(scan_reg) + 16'h0001;
                        state_next = S_XFER;
                    end
                    else
                    begin
                        scan_next = scan_reg + 1'b1;
                    end
                end
            end
            S_XFER:
            begin
                mtype_next = blk_reg[srx_pkg::BLK_DTYPE];
                maddr_next = blk_reg[srx_pkg::BLK_DADDR] + 16'h0002 + {1'b0, done_reg[15:1]};
                if (done_reg == len_reg)
                begin
                    if (odd_reg)
                    begin
                        we_next = 1'b1;
                        mdata_next = {8'h00, lo_reg};
                        be_next = word_dest ? 2'b11 : 2'b01;
                        odd_next = 1'b0;
                    end
                    state_next = S_CNT;
                end
                else
                begin
                    buf_pop = 1'b1;
                    done_next = done_reg + 1'b1;
                    if (!odd_reg)
                    begin
                        lo_next = head_data;
                        odd_next = 1'b1;
                    end
                    else
                    begin
                        we_next = 1'b1;
                        mdata_next = {head_data, lo_reg};
                        be_next = 2'b11;
                        odd_next = 1'b0;
                    end
                end
            end
            S_CNT:
            begin
                we_next = 1'b1;
                mtype_next = blk_reg[srx_pkg::BLK_DTYPE];
                maddr_next = blk_reg[srx_pkg::BLK_DADDR];
                mdata_next = done_reg;
                be_next = 2'b11;
                code_next = srx_pkg::ST_OK;
                cause_next = srx_pkg::CAUSE_DATA;
                state_next = S_REM;
            end
            S_REM:
            begin
                we_next = 1'b1;
                maddr_next = blk_reg[srx_pkg::BLK_DADDR] + 16'h0001;
                mdata_next = 16'(buf_count);
                be_next = 2'b11;
                state_next = S_STAT;
            end
            S_STAT:
            begin
                we_next = 1'b1;
                mtype_next = blk_reg[srx_pkg::BLK_STTYPE];
                maddr_next = blk_reg[srx_pkg::BLK_STOFF] + 16'h0001;
                mdata_next = code_reg;
                be_next = 2'b11;
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= S_IDLE;
            cause_reg <= srx_pkg::CAUSE_NONE;
            len_reg <= 16'h0000;
            done_reg <= 16'h0000;
            lo_reg <= 8'h00;
            odd_reg <= 1'b0;
            scan_reg <= '0;
            tick_reg <= 32'h0000_0000;
            sec_reg <= 16'h0000;
            code_reg <= 16'h0000;
            we_reg <= 1'b0;
            mtype_reg <= 16'h0000;
            maddr_reg <= 16'h0000;
            mdata_reg <= 16'h0000;
            be_reg <= 2'b00;
        end
        else
        begin
            state_reg <= state_next;
            cause_reg <= cause_next;
            len_reg <= len_next;
            done_reg <= done_next;
            lo_reg <= lo_next;
            odd_reg <= odd_next;
            scan_reg <= scan_next;
            tick_reg <= tick_next;
            sec_reg <= sec_next;
            code_reg <= code_next;
            we_reg <= we_next;
            mtype_reg <= mtype_next;
            maddr_reg <= maddr_next;
            mdata_reg <= mdata_next;
            be_reg <= be_next;
        end
    end

    // outputs
    assign PREADY = 1'b1;
    assign PRDATA = prdata_reg;
    assign PSLVERR = err_reg && PSEL && PENABLE;
    assign MEM_WE = we_reg;
    assign MEM_TYPE = mtype_reg;
    assign MEM_ADDR = maddr_reg;
    assign MEM_DATA = mdata_reg;
    assign MEM_BE = be_reg;
endmodule : srx_serial_rx
`default_nettype wire

// ===== test/srx_serial_rx_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srx_serial_rx_asserts #(
    parameter int DEPTH = 64
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic MEM_WE,
    input wire logic [15:0] MEM_DATA,
    input wire logic [1:0] MEM_BE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // read access phase of one register
    logic acc_rd;
    assign acc_rd = PSEL && PENABLE && !PWRITE;
    AST_RXCNT_BOUND: assert property (acc_rd && PADDR == 8'h08 |-> PRDATA <= DEPTH)
        else $error("buffered count above depth");
    AST_PSTAT_FIELDS: assert property (acc_rd && PADDR == 8'h04 |-> PRDATA[31:3] == 29'h0)
        else $error("port status spare bits set");
    AST_CTRL_FIELDS: assert property (acc_rd && PADDR == 8'h00 |-> PRDATA[31:1] == 31'h0)
        else $error("control spare bits set");
    AST_ODD_HIGH: assert property (MEM_WE && MEM_BE == 2'h1 |-> MEM_DATA[15:8] == 8'h00)
        else $error("odd tail high byte not zero");
    AST_BE_LEGAL: assert property (MEM_WE |-> MEM_BE != 2'h0)
        else $error("memory write without lanes");
    AST_ERR_PHASE: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error outside access phase");
    AST_UNMAP: assert property (PSEL && PENABLE && PADDR == 8'h0c |-> PSLVERR && PRDATA == 0)
        else $error("unmapped access not refused");
    AST_READY: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase stalled");
    AST_MAP_OK: assert property (acc_rd && PADDR inside {8'h00, 8'h04, 8'h08} |-> !PSLVERR)
        else $error("mapped read refused");
endmodule : srx_serial_rx_asserts
bind srx_serial_rx srx_serial_rx_asserts #(.DEPTH(DEPTH)) srx_serial_rx_asserts_inst (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_WE(MEM_WE),
    .MEM_DATA(MEM_DATA), .MEM_BE(MEM_BE));
`default_nettype wire

// ===== test/srx_app_mem.sv
`timescale 1ns/1ps
`default_nettype none
module srx_app_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [15:0] typ_in,
    input wire logic [15:0] addr,
    input wire logic [15:0] data,
    input wire logic [1:0] be
);
    logic [15:0] mem [0:255];
    logic [15:0] typ [0:255];
    // wipe to a marker so untouched words stand out
    task clr;
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = 16'hffff;
            typ[i] = 16'hffff;
        end
    endtask : clr
    initial clr();
    // application word memory, byte lanes honoured
    always @(posedge clk)
        if (we)
        begin
            if (be[0]) mem[addr[7:0]][7:0] <= data[7:0];
            if (be[1]) mem[addr[7:0]][15:8] <= data[15:8];
            typ[addr[7:0]] <= typ_in;
        end
endmodule : srx_app_mem
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int DEPTH = 8;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic rxv = 1'b0;
    logic [7:0] rxd = 8'h00;
    wire [31:0] prd;
    wire pready;
    wire perr;
    wire we;
    wire [15:0] mtype;
    wire [15:0] maddr;
    wire [15:0] mdata;
    wire [1:0] mbe;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    srx_serial_rx #(.DEPTH(DEPTH), .TICKS_PER_SECOND(20)) srx_serial_rx_inst (
        .SYS_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .RX_VALID(rxv),
        .RX_DATA(rxd), .MEM_WE(we), .MEM_TYPE(mtype), .MEM_ADDR(maddr), .MEM_DATA(mdata),
        .MEM_BE(mbe));
    srx_app_mem srx_app_mem_inst (.clk(clk), .we(we), .typ_in(mtype), .addr(maddr),
        .data(mdata), .be(mbe));
    task results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chkm(input logic [7:0] a, input logic [15:0] e);
        chk({16'h0, srx_app_mem_inst.mem[a]}, {16'h0, e});
    endtask : chkm
    // one apb transfer, held until pready at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task send(input logic [7:0] b);
        @(posedge clk);
        rxv <= 1'b1;
        rxd <= b;
        @(posedge clk);
        rxv <= 1'b0;
    endtask : send
    // load a request block and start it
    task req(input logic [15:0] cmd, tmo, cnt, dtype);
        logic [15:0] w [11];
        w = '{srx_pkg::BLK_LEN_READ, 0, srx_pkg::MEM_TYPE_WORD, 0, 0, 0, cmd, tmo, cnt, dtype,
            16'h0064};
        srx_app_mem_inst.clr();
        for (int i = 0; i < 11; i++) apb(1'b1, srx_pkg::OFF_BLK + 8'(4 * i), {16'h0, w[i]});
        apb(1'b1, srx_pkg::OFF_CTRL, 32'h1);
    endtask : req
    // wait for idle, then status word and buffer level
    task fin(input logic [15:0] st, input logic [31:0] left);
        do apb(1'b0, srx_pkg::OFF_CTRL, 32'h0); while (rd[0] !== 1'b0);
        chkm(8'h01, st);
        chk(srx_app_mem_inst.typ[8'h01], srx_pkg::MEM_TYPE_WORD);
        apb(1'b0, srx_pkg::OFF_RXCNT, 32'h0);
        chk(rd, left);
        apb(1'b0, srx_pkg::OFF_PSTAT, 32'h0);
    endtask : fin
    task s_reset;
        apb(1'b0, srx_pkg::OFF_RXCNT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
    endtask : s_reset
    task s_bytes;
        logic [7:0] c [6];
        c = '{8'h68, 8'h65, 8'h6c, 8'h6c, 8'h6f, 8'h21};
        for (int i = 0; i < 6; i++) send(c[i]);
        req(srx_pkg::CMD_READ_BYTES, 16'h001e, 16'h0005, srx_pkg::MEM_TYPE_WORD);
        fin(srx_pkg::ST_OK, 32'h1);
        chk(rd[2:1], srx_pkg::CAUSE_DATA);
        chkm(8'h64, 16'h0005);
        chkm(8'h65, 16'h0001);
        chkm(8'h66, 16'h6568);
        chkm(8'h67, 16'h6c6c);
        chkm(8'h68, 16'h006f);
        chk(srx_app_mem_inst.typ[8'h66], srx_pkg::MEM_TYPE_WORD);
    endtask : s_bytes
    task s_string;
        send(8'h61);
        send(8'h0d);
        send(8'h7a);
        req(srx_pkg::CMD_READ_STRING, 16'h001e, 16'h000d, 16'h0008);
        fin(srx_pkg::ST_OK, 32'h1);
        chkm(8'h64, 16'h0003);
        chkm(8'h66, 16'h6121);
        chkm(8'h67, 16'hff0d);
        chk(srx_app_mem_inst.typ[8'h66], 16'h0008);
    endtask : s_string
    task s_zero_timeout;
        req(srx_pkg::CMD_READ_BYTES, 16'h001e, 16'h0000, srx_pkg::MEM_TYPE_WORD);
        fin(srx_pkg::ST_OK, 32'h1);
        chkm(8'h65, 16'h0001);
        chkm(8'h66, 16'hffff);
        req(srx_pkg::CMD_READ_BYTES, 16'h0001, 16'h000a, srx_pkg::MEM_TYPE_WORD);
        fin(srx_pkg::ST_TIMEOUT, 32'h1);
        chk(rd[2:1], srx_pkg::CAUSE_TIMEOUT);
        chkm(8'h64, 16'hffff);
    endtask : s_zero_timeout
    task s_cancel_bad;
        req(srx_pkg::CMD_READ_STRING, 16'h0000, 16'h0055, srx_pkg::MEM_TYPE_WORD);
        repeat (100) @(posedge clk);
        apb(1'b0, srx_pkg::OFF_CTRL, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, srx_pkg::OFF_BLK, 32'h5);
        chk(er, 1'b1);
        apb(1'b1, srx_pkg::OFF_CTRL, 32'h2);
        fin(srx_pkg::ST_CANCELLED, 32'h1);
        chk(rd[2:1], srx_pkg::CAUSE_FAIL);
        for (int i = 0; i < 2; i++)
        begin
            req(i ? srx_pkg::CMD_READ_STRING : 16'h1134, 16'h001e, i ? 16'h0100 : 16'h0005,
                srx_pkg::MEM_TYPE_WORD);
            fin(srx_pkg::ST_BADREQ, 32'h1);
            chkm(8'h64, 16'hffff);
        end
    endtask : s_cancel_bad
    task s_overflow;
        for (int i = 0; i < DEPTH; i++) send(8'h30 + 8'(i));
        apb(1'b0, srx_pkg::OFF_PSTAT, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, srx_pkg::OFF_PSTAT, 32'h1);
        apb(1'b0, srx_pkg::OFF_PSTAT, 32'h0);
        chk(rd[0], 1'b0);
        req(srx_pkg::CMD_READ_BYTES, 16'h001e, 16'h0000, srx_pkg::MEM_TYPE_WORD);
        fin(srx_pkg::ST_OK, DEPTH);
        chkm(8'h65, 16'(DEPTH));
    endtask : s_overflow
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        s_reset();
        s_bytes();
        s_string();
        s_zero_timeout();
        s_cancel_bad();
        s_overflow();
        results();
    end
    // watchdog against a hung request
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end
endmodule : testbench
`default_nettype wire
